//--- hw/arb_pkg.sv
// Operation
// R1: input current is a two's-complement field in bits 15:1, one step is 2 mA.
// R2: input current is positive from supply pin to mid-rail node and negative the other way.
// R3: input current saturates at codes 7830h (negative end) and 7D0h (positive end).
// R4: battery current is a two's-complement field in bits 15:2, one step is 4 mA.
// R5: battery current is positive while charging and negative while discharging.
// R6: battery current reads zero whenever charge enable is low.
// R7: a polarity change during a battery current conversion aborts it and the field reads 2000h.
// R8: battery current is only zero or positive in forward mode and only zero or negative on battery alone.
// R9: battery current clamps at codes 38ADh (negative end) and 3E8h (positive end).
// R10: input voltage is unsigned in bits 14:2, 3.97 mV steps, clamped high at 11B6h, zero after reset.
// R11: mid-rail voltage is unsigned in bits 14:2, 3.97 mV steps, clamped high at 11B6h, zero after reset.
// R12: battery and system voltage are unsigned in bits 12:1, 1.99 mV steps, clamped at AF0h, zero after reset.
// R13: both current results read zero after reset until a conversion updates them.
// R14: results hold the latest measurement and are never cleared by the converter.
// R15: a channel is converted only while its channel-off bit is 0.
// R16: reserved bits read zero and host writes to the results have no effect.
package arb_pkg;
    // byte offsets of the result words, low byte first
    localparam logic [7:0] ARB_IIN_OFS = 8'h28;
    localparam logic [7:0] ARB_IBAT_OFS = 8'h2a;
    localparam logic [7:0] ARB_VIN_OFS = 8'h2c;
    localparam logic [7:0] ARB_VMID_OFS = 8'h2e;
    localparam logic [7:0] ARB_VBAT_OFS = 8'h30;
    localparam logic [7:0] ARB_VSYS_OFS = 8'h32;
    localparam logic [7:0] ARB_TS_OFS = 8'h34;
    localparam int ARB_NUM_REGS = 7;
    localparam logic [15:0] ARB_RESET_WORD = 16'h0000;

    // channel codes, equal to the word index from the first offset
    typedef logic [2:0] arb_chan_t;
    localparam arb_chan_t ARB_CH_IIN = 3'h0;
    localparam arb_chan_t ARB_CH_IBAT = 3'h1;
    localparam arb_chan_t ARB_CH_VIN = 3'h2;
    localparam arb_chan_t ARB_CH_VMID = 3'h3;
    localparam arb_chan_t ARB_CH_VBAT = 3'h4;
    localparam arb_chan_t ARB_CH_VSYS = 3'h5;
    localparam arb_chan_t ARB_CH_TS = 3'h6;

    // field positions and widths
    localparam int ARB_IIN_LSB = 1;
    localparam int ARB_IIN_W = 15;
    localparam int ARB_IBAT_LSB = 2;
    localparam int ARB_IBAT_W = 14;
    localparam int ARB_VIN_LSB = 2;
    localparam int ARB_VIN_W = 13;
    localparam int ARB_VBAT_LSB = 1;
    localparam int ARB_VBAT_W = 12;
    localparam int ARB_TS_LSB = 0;
    localparam int ARB_TS_W = 12;

    // clamp codes
    localparam logic [14:0] ARB_IIN_NEG_END = 15'h7830;
    localparam logic [14:0] ARB_IIN_POS_END = 15'h07d0;
    localparam logic [13:0] ARB_IBAT_NEG_END = 14'h38ad;
    localparam logic [13:0] ARB_IBAT_POS_END = 14'h03e8;
    localparam logic [13:0] ARB_IBAT_ABORT = 14'h2000;
    localparam logic [12:0] ARB_VIN_MAX = 13'h11b6;
    localparam logic [11:0] ARB_VBAT_MAX = 12'haf0;
    localparam logic [11:0] ARB_TS_MAX = 12'h3ff;

    // channel-off bit positions in the disable byte
    localparam int ARB_OFF_IIN = 7;
    localparam int ARB_OFF_IBAT = 6;
    localparam int ARB_OFF_VIN = 5;
    localparam int ARB_OFF_VBAT = 4;
    localparam int ARB_OFF_VSYS = 3;
    localparam int ARB_OFF_TS = 2;
    localparam int ARB_OFF_VMID = 0;

    localparam int ARB_RAW_W = 18;
    localparam logic [3:0] ARB_BITS_PER_BYTE = 4'h8;
endpackage : arb_pkg

//--- hw/arb_meas_if.sv
`timescale 1ns/1ns
`default_nettype none
// one conversion result on its way to clamping
interface arb_meas_if;
    import arb_pkg::*;
    logic valid;
    arb_chan_t chan;
    logic abort;
    logic signed [ARB_RAW_W-1:0] raw;
    logic signed [ARB_RAW_W-1:0] lo;
    logic signed [ARB_RAW_W-1:0] hi;
    logic q_valid;
    arb_chan_t q_chan;
    logic q_abort;
    logic signed [ARB_RAW_W-1:0] q_field;
    modport src (output valid, chan, abort, raw, lo, hi, input q_valid, q_chan, q_abort, q_field);
    modport clamp (input valid, chan, abort, raw, lo, hi, output q_valid, q_chan, q_abort, q_field);
endinterface : arb_meas_if
`default_nettype wire

//--- hw/arb_clamp.sv
`timescale 1ns/1ns
`default_nettype none
module arb_clamp
    import arb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    arb_meas_if.clamp m
);
    // saturate the raw code between the channel limits, one stage deep
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            m.q_valid <= 1'b0;
            m.q_chan <= ARB_CH_IIN;
            m.q_abort <= 1'b0;
            m.q_field <= '0;
        end else begin
            m.q_valid <= m.valid;
            m.q_chan <= m.chan;
            m.q_abort <= m.abort;
            if (m.raw < m.lo) begin // [R3] [R9]
                m.q_field <= m.lo;
            end else if (m.raw > m.hi) begin // [R3] [R9] [R10] [R11] [R12]
                m.q_field <= m.hi;
            end else begin
                m.q_field <= m.raw;
            end
        end
    end
endmodule : arb_clamp
`default_nettype wire

//--- hw/arb_result_bank.sv
`timescale 1ns/1ns
`default_nettype none
module arb_result_bank
    import arb_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic conv_valid,
    input wire logic [2:0] conv_chan,
    input wire logic signed [17:0] conv_value,
    input wire logic conv_abort,
    input wire logic charge_enable,
    input wire logic forward_mode,
    input wire logic [7:0] channel_off
);
    typedef enum {
        ARB_ST_IDLE,
        ARB_ST_ADDR,
        ARB_ST_AACK,
        ARB_ST_PTR,
        ARB_ST_PACK,
        ARB_ST_WR,
        ARB_ST_WACK,
        ARB_ST_RD,
        ARB_ST_RACK
    } arb_state_e;

    arb_meas_if m ();

    logic [15:0] res_r [ARB_NUM_REGS];
    logic scl_m_r;
    logic scl_s_r;
    logic scl_q_r;
    logic sda_m_r;
    logic sda_s_r;
    logic sda_q_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    arb_state_e st_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic acked_r;
    logic oe_n_r;
    logic load_byte;
    logic [7:0] byte_out;
    logic [15:0] cur_word;
    logic [15:0] hold_r;
    logic [7:0] hold_ptr_r;

    // is the channel's disable bit set
    function automatic logic chan_is_off(input arb_chan_t ch, input logic [7:0] off);
        logic r;
        r = 1'b1;
        unique case (ch)
            ARB_CH_IIN: r = off[ARB_OFF_IIN];
            ARB_CH_IBAT: r = off[ARB_OFF_IBAT];
            ARB_CH_VIN: r = off[ARB_OFF_VIN];
            ARB_CH_VMID: r = off[ARB_OFF_VMID];
            ARB_CH_VBAT: r = off[ARB_OFF_VBAT];
            ARB_CH_VSYS: r = off[ARB_OFF_VSYS];
            ARB_CH_TS: r = off[ARB_OFF_TS];
            default: r = 1'b1;
        endcase
        return r;
    endfunction : chan_is_off

    // put a clamped field at its position, reserved bits zero
    function automatic logic [15:0] place(input arb_chan_t ch, input logic [ARB_RAW_W-1:0] f, input logic ab);
        logic [15:0] w;
        w = ARB_RESET_WORD;
        unique case (ch)
            ARB_CH_IIN: w = 16'(f[ARB_IIN_W-1:0]) << ARB_IIN_LSB; // [R1] [R2]
            ARB_CH_IBAT: begin
                if (ab) begin
                    w = 16'(ARB_IBAT_ABORT) << ARB_IBAT_LSB; // [R7]
                end else begin
                    w = 16'(f[ARB_IBAT_W-1:0]) << ARB_IBAT_LSB; // [R4] [R5]
                end
            end
            ARB_CH_VIN, ARB_CH_VMID: w = 16'(f[ARB_VIN_W-1:0]) << ARB_VIN_LSB; // [R10] [R11] [R16]
            ARB_CH_VBAT, ARB_CH_VSYS: w = 16'(f[ARB_VBAT_W-1:0]) << ARB_VBAT_LSB; // [R12] [R16]
            ARB_CH_TS: w = 16'(f[ARB_TS_W-1:0]) << ARB_TS_LSB;
            default: w = ARB_RESET_WORD;
        endcase
        return w;
    endfunction : place

    // word at a byte address, zero outside the bank
    function automatic logic [15:0] word_at(input logic [7:0] a);
        logic [7:0] rel;
        logic [15:0] w;
        rel = a - ARB_IIN_OFS;
        w = ARB_RESET_WORD;
        if (a >= ARB_IIN_OFS && a <= ARB_TS_OFS + 8'h01) begin
            w = res_r[rel[3:1]];
        end
        return w;
    endfunction : word_at

    // limits per channel; sign limits follow the power mode
    always_comb begin
        m.valid = conv_valid & ~chan_is_off(conv_chan, channel_off); // [R15]
        m.chan = conv_chan;
        m.abort = conv_abort & (conv_chan == ARB_CH_IBAT); // [R7]
        m.raw = conv_value;
        m.lo = '0;
        m.hi = '0;
        unique case (conv_chan)
            ARB_CH_IIN: begin
                m.lo = ARB_RAW_W'(signed'(ARB_IIN_NEG_END)); // [R3]
                m.hi = ARB_RAW_W'(signed'(ARB_IIN_POS_END)); // [R3]
            end
            ARB_CH_IBAT: begin
                if (forward_mode) begin
                    m.lo = '0; // [R8]
                    m.hi = ARB_RAW_W'(signed'(ARB_IBAT_POS_END)); // [R9]
                end else begin
                    m.lo = ARB_RAW_W'(signed'(ARB_IBAT_NEG_END)); // [R9]
                    m.hi = '0; // [R8]
                end
            end
            ARB_CH_VIN, ARB_CH_VMID: m.hi = ARB_RAW_W'(ARB_VIN_MAX); // [R10] [R11]
            ARB_CH_VBAT, ARB_CH_VSYS: m.hi = ARB_RAW_W'(ARB_VBAT_MAX); // [R12]
            ARB_CH_TS: m.hi = ARB_RAW_W'(ARB_TS_MAX);
            default: m.valid = 1'b0;
        endcase
    end

    arb_clamp u_clamp (
        .mclk(mclk),
        .rst(rst),
        .m(m.clamp)
    );

    // result words: zero at reset, then the latest value, or zero for battery current while charge enable is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ARB_NUM_REGS; i++) begin
                res_r[i] <= ARB_RESET_WORD; // [R10] [R11] [R12] [R13]
            end
        end else begin
            if (m.q_valid) begin
                res_r[m.q_chan] <= place(m.q_chan, m.q_field, m.q_abort); // [R14]
            end
            if (!charge_enable) begin
                res_r[ARB_CH_IBAT] <= ARB_RESET_WORD; // [R6]
            end
        end
    end

    // two-stage synchronisers, then one more stage for edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
        end
    end

    // bus conditions
    assign scl_rise = scl_s_r & ~scl_q_r;
    assign scl_fall = ~scl_s_r & scl_q_r;
    assign bus_start = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
    assign bus_stop = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;

    // next read byte: high byte from the snapshot taken with its low byte
    assign load_byte = scl_fall & (((st_r == ARB_ST_AACK) & rw_r) | ((st_r == ARB_ST_RACK) & acked_r));
    always_comb begin
        cur_word = word_at(ptr_r);
        byte_out = cur_word[15:8];
        if (!ptr_r[0]) begin
            byte_out = cur_word[7:0];
        end else if (hold_ptr_r == {ptr_r[7:1], 1'b0}) begin
            byte_out = hold_r[15:8];
        end
    end

    // snapshot a word when its low byte goes out, so the pair never tears
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_r <= ARB_RESET_WORD;
            hold_ptr_r <= 8'hff;
        end else if (bus_start) begin
            hold_ptr_r <= 8'hff; // a new transfer never reuses an old snapshot
        end else if (load_byte) begin
            if (!ptr_r[0]) begin
                hold_r <= word_at(ptr_r);
                hold_ptr_r <= ptr_r;
            end else begin
                hold_ptr_r <= 8'hff;
            end
        end
    end

    // serial slave: address, pointer, ignored writes, auto-incrementing reads
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= ARB_ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            acked_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (bus_start) begin
            st_r <= ARB_ST_ADDR;
            bit_cnt_r <= 4'h0;
            oe_n_r <= 1'b1;
        end else if (bus_stop) begin
            st_r <= ARB_ST_IDLE;
            oe_n_r <= 1'b1;
        end else begin
            unique case (st_r)
                ARB_ST_IDLE: oe_n_r <= 1'b1;
                ARB_ST_ADDR, ARB_ST_PTR, ARB_ST_WR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == ARB_BITS_PER_BYTE) begin
                        bit_cnt_r <= 4'h0;
                        if (st_r == ARB_ST_ADDR) begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_r <= shift_r[0];
                                oe_n_r <= 1'b0;
                                st_r <= ARB_ST_AACK;
                            end else begin
                                st_r <= ARB_ST_IDLE;
                            end
                        end else if (st_r == ARB_ST_PTR) begin
                            ptr_r <= shift_r;
                            oe_n_r <= 1'b0;
                            st_r <= ARB_ST_PACK;
                        end else begin
                            ptr_r <= ptr_r + 8'h01; // data dropped [R16]
                            oe_n_r <= 1'b0;
                            st_r <= ARB_ST_WACK;
                        end
                    end
                end
                ARB_ST_AACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r) begin
                            tx_r <= byte_out;
                            oe_n_r <= byte_out[7];
                            st_r <= ARB_ST_RD;
                        end else begin
                            oe_n_r <= 1'b1;
                            st_r <= ARB_ST_PTR;
                        end
                    end
                end
                ARB_ST_PACK, ARB_ST_WACK: begin
                    if (scl_fall) begin
                        oe_n_r <= 1'b1;
                        bit_cnt_r <= 4'h0;
                        st_r <= ARB_ST_WR;
                    end
                end
                ARB_ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == ARB_BITS_PER_BYTE) begin
                            oe_n_r <= 1'b1;
                            ptr_r <= ptr_r + 8'h01;
                            st_r <= ARB_ST_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            oe_n_r <= tx_r[6];
                        end
                    end
                end
                ARB_ST_RACK: begin
                    if (scl_rise) begin
                        acked_r <= ~sda_s_r;
                    end else if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (acked_r) begin
                            tx_r <= byte_out;
                            oe_n_r <= byte_out[7];
                            st_r <= ARB_ST_RD;
                        end else begin
                            st_r <= ARB_ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // open-drain data pin: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_r;
endmodule : arb_result_bank
`default_nettype wire

//--- verification/arb_result_bank_props.sv
`timescale 1ns/1ns
`default_nettype none
// serial pin checks on the result bank
module arb_result_bank_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // clock held high over three samples
    sequence scl_high_run;
        scl_in [*3];
    endsequence
    // data falls while clock stays high
    sequence start_seen;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    // data rises while clock stays high
    sequence stop_seen;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0) rst |-> sda_oe_n)
        else $error("sda driven in reset");
    a_open_drain: assert property (disable iff (1'b0) sda_out == 1'b0)
        else $error("sda driven high");
    a_quiet_after_reset: assert property (disable iff (1'b0) $fell(rst) |-> sda_oe_n [*8])
        else $error("sda driven just after reset");
    a_drive_low_phase: assert property ($fell(sda_oe_n) |-> !$past(scl_in))
        else $error("drive began with clock high");
    a_release_low_phase: assert property ($rose(sda_oe_n) |-> !$past(scl_in))
        else $error("release with clock high");
    a_hold_high_phase: assert property (scl_high_run |-> $stable(sda_oe_n))
        else $error("sda drive moved with clock high");
    a_start_free: assert property (start_seen |-> sda_oe_n [*4])
        else $error("sda driven around start");
    a_stop_free: assert property (stop_seen |-> $past(sda_oe_n))
        else $error("stop caused by release");
endmodule : arb_result_bank_props

bind arb_result_bank arb_result_bank_props u_props (
    .mclk(mclk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n)
);
`default_nettype wire

//--- verification/arb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host on the serial bus; sda released floats high by pull-up
module arb_host_model #(
    parameter int QTR = 6
) (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // set both lines then let one phase pass
    task automatic step(input logic c, input logic p);
        scl <= c;
        sda_pull <= p;
        repeat (QTR) @(posedge mclk);
    endtask : step
    // one bit: data set in low phase, sampled at end of high phase
    task automatic bit_io(input logic b, output logic got);
        step(1'b0, ~b);
        step(1'b1, ~b);
        got = sda_line;
        step(1'b0, ~b);
    endtask : bit_io
    task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack, ack_seen);
    endtask : byte_io
    // start or repeated start
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop
    // word read: low byte acked, high byte nacked
    task automatic read_word(input logic [6:0] dev, input logic [7:0] ofs, output logic [15:0] w,
                             output logic [2:0] acks);
        logic [7:0] junk;
        start();
        byte_io({dev, 1'b0}, 1'b1, junk, acks[2]);
        byte_io(ofs, 1'b1, junk, acks[1]);
        start();
        byte_io({dev, 1'b1}, 1'b1, junk, acks[0]);
        byte_io(8'hff, 1'b0, w[7:0], junk[0]);
        byte_io(8'hff, 1'b1, w[15:8], junk[0]);
        stop();
    endtask : read_word
    task automatic write_word(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d);
        logic [7:0] junk;
        start();
        byte_io({dev, 1'b0}, 1'b1, junk, junk[0]);
        byte_io(ofs, 1'b1, junk, junk[0]);
        byte_io(d[7:0], 1'b1, junk, junk[0]);
        byte_io(d[15:8], 1'b1, junk, junk[0]);
        stop();
    endtask : write_word
endmodule : arb_host_model
`default_nettype wire

//--- verification/adc_result_register_bank_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adc_result_register_bank_tb_top;
    import arb_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;
    logic mclk, rst, scl, pull, sda_line, sda_out, sda_oe_n;
    logic conv_valid, conv_abort, charge_enable, forward_mode;
    logic [2:0] conv_chan;
    logic signed [17:0] conv_value;
    logic [7:0] channel_off;
    int bad_count, n_tests, cycles;

    // open-drain wire with pull-up
    assign sda_line = ~pull & (sda_oe_n | sda_out);

    arb_result_bank #(.DEV_ADDR(DEV)) dut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_value(conv_value), .conv_abort(conv_abort),
        .charge_enable(charge_enable), .forward_mode(forward_mode), .channel_off(channel_off)
    );
    arb_host_model #(.QTR(6)) host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(pull));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [15:0] exp);
        logic [15:0] w;
        logic [2:0] a;
        host.read_word(DEV, ofs, w, a);
        check(what, w, exp);
    endtask : rd_chk

    // one conversion pulse, then time for the store stage
    task automatic conv(input logic [2:0] ch, input int val, input logic ab);
        conv_valid <= 1'b1;
        conv_chan <= ch;
        conv_value <= 18'(val);
        conv_abort <= ab;
        @(posedge mclk);
        conv_valid <= 1'b0;
        conv_abort <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : conv

    // every word and an unmapped one read zero
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset word", 8'h28 + 8'(2 * i), 16'h0000);
        end
    endtask : t_reset

    task automatic t_in_current();
        int v[4] = '{3000, -5000, 100, -1};
        logic [15:0] e[4] = '{16'h0fa0, 16'hf060, 16'h00c8, 16'hfffe};
        for (int i = 0; i < 4; i++) begin
            conv(ARB_CH_IIN, v[i], 1'b0);
            rd_chk("input current", ARB_IIN_OFS, e[i]);
        end
    endtask : t_in_current

    // modes, abort and charge-enable clear
    task automatic t_bat_current();
        logic fm[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        logic ce[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        int v[7] = '{2000, -5, -3000, -100, 50, 0, -100};
        logic ab[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        logic [15:0] e[7] = '{16'h0fa0, 16'h0000, 16'he2b4, 16'hfe70, 16'h0000, 16'h8000, 16'h0000};
        for (int i = 0; i < 7; i++) begin
            forward_mode <= fm[i];
            charge_enable <= ce[i];
            conv(ARB_CH_IBAT, v[i], ab[i]);
            rd_chk("battery current", ARB_IBAT_OFS, e[i]);
        end
        charge_enable <= 1'b1;
    endtask : t_bat_current

    task automatic t_voltages();
        logic [2:0] c[8] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6};
        int v[8] = '{5000, -7, 1000, 4535, 3000, 100, 2801, 5000};
        logic [7:0] o[8] = '{8'h2c, 8'h2c, 8'h2e, 8'h2e, 8'h30, 8'h32, 8'h32, 8'h34};
        logic [15:0] e[8] = '{16'h46d8, 16'h0000, 16'h0fa0, 16'h46d8, 16'h15e0, 16'h00c8, 16'h15e0, 16'h03ff};
        for (int i = 0; i < 8; i++) begin
            conv(c[i], v[i], 1'b0);
            rd_chk("voltage", o[i], e[i]);
        end
    endtask : t_voltages

    // disabled channel keeps its last word
    task automatic t_off_hold();
        channel_off <= 8'h80;
        conv(ARB_CH_IIN, 20, 1'b0);
        rd_chk("channel off", ARB_IIN_OFS, 16'hfffe);
        channel_off <= 8'h00;
        conv(3'h7, 20, 1'b0);
        conv(ARB_CH_IIN, 20, 1'b0);
        rd_chk("channel on", ARB_IIN_OFS, 16'h0028);
    endtask : t_off_hold

    // host write dropped, foreign address refused
    task automatic t_write_refuse();
        logic [15:0] w;
        logic [2:0] a;
        host.write_word(DEV, ARB_IIN_OFS, 16'h1234);
        rd_chk("after write", ARB_IIN_OFS, 16'h0028);
        host.read_word(DEV ^ 7'h01, ARB_IIN_OFS, w, a);
        check("foreign acks", {13'h0, a}, 16'h0007);
        host.read_word(DEV, ARB_IBAT_OFS, w, a);
        check("own acks", {13'h0, a}, 16'h0000);
        check("battery current held", w, 16'h0000);
    endtask : t_write_refuse

    // second reset in mid-run clears the held input current word
    task automatic t_reset_again();
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk("reset again", ARB_IIN_OFS, 16'h0000);
    endtask : t_reset_again

    initial begin
        rst = 1'b1;
        conv_valid = 1'b0;
        conv_abort = 1'b0;
        conv_chan = 3'h0;
        conv_value = 18'h00000;
        charge_enable = 1'b1;
        forward_mode = 1'b1;
        channel_off = 8'h00;
        bad_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset();
        t_in_current();
        t_bat_current();
        t_voltages();
        t_off_hold();
        t_write_refuse();
        t_reset_again();
        report_and_stop();
    end
endmodule : adc_result_register_bank_tb_top
`default_nettype wire
